// [design/fcep_pkg.sv]
// constants, types and carriers for the flash cache, correction and protection block
package fcep_pkg;
    localparam int unsigned N_LINES    = 8;
    localparam int unsigned LINE_BYTES = 64;
    localparam int unsigned N_ROWS     = 256;
    localparam int unsigned ROW_BYTES  = 256;
    localparam int unsigned ROW_CHK    = 32;
    localparam int unsigned GRP_BYTES  = 8;

    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam logic [3:0] OFF_EADR = 4'h8;

    localparam int unsigned CTRL_CACHE  = 0;
    localparam int unsigned CTRL_ECC    = 1;
    localparam int unsigned CTRL_IRQ    = 2;
    localparam int unsigned CTRL_SECURE = 3;
    localparam int unsigned STAT_SBE    = 0;
    localparam int unsigned STAT_DBE    = 1;
    localparam int unsigned STAT_BUSY   = 2;
    localparam int unsigned STAT_SECURE = 3;

    localparam logic RST_CACHE_EN = 1'h1;
    localparam logic RST_ECC_EN   = 1'h1;
    localparam logic RST_IRQ_EN   = 1'h0;
    localparam logic [7:0] ERASED_CHK = 8'hFF;

    typedef enum logic [1:0] {
        LVL_OPEN    = 2'h0,
        LVL_FACTORY = 2'h1,
        LVL_FIELD   = 2'h2,
        LVL_FULL    = 2'h3
    } fcep_lvl_t;

    typedef enum logic [1:0] {
        SRC_INT  = 2'h0,
        SRC_SWD  = 2'h1,
        SRC_JTAG = 2'h2,
        SRC_RSVD = 2'h3
    } fcep_src_t;

    typedef enum logic [1:0] {
        CMD_READ      = 2'h0,
        CMD_PROGRAM   = 2'h1,
        CMD_ERASE_ALL = 2'h2,
        CMD_SET_PROT  = 2'h3
    } fcep_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FILL  = 3'h1,
        ST_RESP  = 3'h3,
        ST_PROG  = 3'h2,
        ST_PDONE = 3'h6
    } fcep_st_t;

    typedef struct packed {
        fcep_cmd_t   cmd;
        fcep_src_t   src;
        logic [16:0] addr;   // bit 16 selects the auxiliary region
        logic [63:0] wdata;
        fcep_lvl_t   lvl;
    } fcep_prog_t;

    typedef struct packed {
        logic        aux;
        logic [12:0] grp;
        logic        wr;
        logic        erase;
        logic [63:0] wdata;
        logic [7:0]  wchk;
    } fcep_flash_t;

    typedef struct packed {
        logic [63:0] data;
        logic        sbe;
        logic        dbe;
    } fcep_ecc_t;

    typedef struct packed {
        fcep_st_t                st;
        logic [2:0]              cnt;
        logic [2:0]              rr;
        logic                    byp;
        logic                    lbad;
        logic [N_LINES-1:0][9:0] tag;
        logic [N_LINES-1:0]      vld;
        logic [15:0]             faddr;
        logic [7:0]              fdata;
        logic                    ferr;
        logic                    cache_en;
        logic                    ecc_en;
        logic                    irq_en;
        logic                    secure;
        logic                    sbe;
        logic                    dbe;
        logic                    irq;
        logic                    pwr;
        logic [12:0]             eaddr;
        logic [N_ROWS-1:0][1:0]  prot;
        fcep_prog_t              pc;
        logic                    perr;
        logic [63:0]             prdata;
        fcep_flash_t             fl;
        logic [31:0]             rdata;
    } fcep_state_t;
endpackage

// [design/fcep_top.sv]
// flash access path: instruction cache, check-bit correction, row protection, programming
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module fcep_top
    import fcep_pkg::*;
(
    input  wire logic        mclk_i,       // 40 MHz clock
    input  wire logic        nrst_i,       // async reset, active low
    input  wire logic [3:0]  reg_addr_i,   // register byte address
    input  wire logic [31:0] reg_wdata_i,  // register write data
    input  wire logic        reg_wr_i,     // register write strobe
    input  wire logic        reg_rd_i,     // register read strobe
    output logic      [31:0] reg_rdata_o,  // read data, cycle after strobe
    input  wire logic        fetch_req_i,  // core fetch request, held
    input  wire logic [16:0] fetch_addr_i, // fetch byte address
    output logic             fetch_rdy_o,  // fetch answer pulse
    output logic      [7:0]  fetch_data_o, // fetched byte
    output logic             fetch_err_o,  // fetch fault
    input  wire logic        prog_req_i,   // programming request, held
    input  wire fcep_prog_t  prog_i,       // programming command
    output logic             prog_done_o,  // programming answer pulse
    output logic             prog_err_o,   // command refused
    output logic      [63:0] prog_rdata_o, // read result
    output fcep_flash_t      flash_o,      // flash array command
    output logic             flash_req_o,  // flash access request
    output logic             flash_pwr_o,  // flash array power
    input  wire logic        flash_ack_i,  // flash access done
    input  wire logic [63:0] flash_data_i, // flash read data
    input  wire logic [7:0]  flash_chk_i,  // check byte of that group
    output logic             ecc_irq_o,    // error interrupt level
    output logic             dbg_port_en_o // external ports allowed
);
    logic [1:0]  rs_q;
    logic        rst_n;
    fcep_state_t q;
    fcep_state_t d;
    logic [63:0] line_mem [0:N_LINES*(LINE_BYTES/GRP_BYTES)-1];
    logic        mem_we;
    logic [5:0]  mem_wi;
    logic [63:0] mem_wd;
    logic [N_LINES-1:0] hit_v;
    logic        hit;
    logic [2:0]  hit_idx;
    logic [63:0] hit_word;
    fcep_ecc_t   dec;
    fcep_lvl_t   row_lvl;
    logic        p_ext;
    logic        p_ok;
    logic [63:0] fill_word;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    // check bits at power-of-two positions, overall parity on top
    function automatic logic [7:0] ecc_gen(input logic [63:0] dat);
        logic [6:0] s;
        int         k;
        s = 7'h00;
        k = 0;
        for (int pos = 1; pos < 72; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                if (dat[k])
                    s = s ^ 7'(pos);
                k++;
            end
        end
        return {(^dat) ^ (^s), s};
    endfunction

    function automatic fcep_ecc_t ecc_fix(input logic [63:0] dat, input logic [7:0] chk);
        fcep_ecc_t  r;
        logic [7:0] gen;
        logic [6:0] syn;
        logic       par;
        int         k;
        gen = ecc_gen(dat);
        syn = gen[6:0] ^ chk[6:0];
        par = (^dat) ^ (^chk);
        r.data = dat;
        r.sbe = par;
        r.dbe = !par && (syn != 7'h00);
        k = 0;
        for (int pos = 1; pos < 72; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                if (par && (syn == 7'(pos)))
                    r.data[k] = !dat[k];
                k++;
            end
        end
        return r;
    endfunction

    // level table: read and write for external and internal side
    function automatic logic access_ok(input fcep_lvl_t lvl, input logic ext, input logic wr);
        case (lvl)
            LVL_OPEN:    access_ok = 1'b1;
            LVL_FACTORY: access_ok = wr || !ext;
            LVL_FIELD:   access_ok = !ext;
            LVL_FULL:    access_ok = !ext && !wr;
            default:     access_ok = 1'b0;
        endcase
    endfunction

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rs_q <= 2'h0;
        else
            rs_q <= {rs_q[0], 1'b1};
    end
    assign rst_n = rs_q[1];

    // fully associative lookup over every line
    for (genvar i = 0; i < N_LINES; i++)
    begin : g_hit
        assign hit_v[i] = q.vld[i] && (q.tag[i] == fetch_addr_i[15:6]);
    end

    always_comb
    begin
        hit_idx = 3'h0;
        for (int i = 0; i < N_LINES; i++)
        begin
            if (hit_v[i])
                hit_idx = 3'(i);
        end
    end
    assign hit      = |hit_v;
    assign hit_word = line_mem[{hit_idx, fetch_addr_i[5:3]}];
    assign dec      = ecc_fix(flash_data_i, flash_chk_i);
    assign row_lvl  = fcep_lvl_t'(q.prot[prog_i.addr[15:8]]);
    assign p_ext    = prog_i.src != SRC_INT;
    // every source other than SRC_INT counts as external, SRC_RSVD included
    assign p_ok     = prog_i.src != SRC_RSVD && !(p_ext && q.secure);
    assign fill_word = q.ecc_en ? dec.data : flash_data_i;

    always_comb
    begin
        d = q;
        mem_we = 1'b0;
        mem_wi = {q.rr, q.cnt};
        mem_wd = fill_word;
        d.rdata = 32'h0000_0000;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                OFF_CTRL: d.rdata = {28'h000_0000, q.secure, q.irq_en, q.ecc_en, q.cache_en};
                OFF_STAT: d.rdata = {28'h000_0000, q.secure, q.st != ST_IDLE, q.dbe, q.sbe};
                OFF_EADR: d.rdata = {19'h0_0000, q.eaddr};
                default:  d.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                OFF_CTRL:
                begin
                    d.cache_en = reg_wdata_i[CTRL_CACHE];
                    d.ecc_en   = reg_wdata_i[CTRL_ECC];
                    d.irq_en   = reg_wdata_i[CTRL_IRQ];
                    d.secure   = q.secure | reg_wdata_i[CTRL_SECURE];
                    if (!reg_wdata_i[CTRL_CACHE])
                        d.vld = '0;
                end
                OFF_STAT:
                begin
                    d.sbe = q.sbe & !reg_wdata_i[STAT_SBE];
                    d.dbe = q.dbe & !reg_wdata_i[STAT_DBE];
                end
                default:
                begin
                end
            endcase
        end
        case (q.st)
            ST_IDLE:
            begin
                if (prog_req_i)
                begin
                    d.pc = prog_i;
                    d.perr = 1'b0;
                    d.fl = '{aux: prog_i.addr[16], grp: prog_i.addr[15:3], wr: 1'b0,
                             erase: 1'b0, wdata: prog_i.wdata, wchk: ERASED_CHK};
                    d.st = ST_PROG;
                    case (prog_i.cmd)
                        CMD_READ:
                            d.perr = !p_ok || !access_ok(row_lvl, p_ext, 1'b0);
                        CMD_PROGRAM:
                        begin
                            d.perr = !p_ok || !access_ok(row_lvl, p_ext, 1'b1)
                                     || (prog_i.addr[16] && q.ecc_en);
                            d.fl.wr = 1'b1;
                            if (q.ecc_en)
                                d.fl.wchk = ecc_gen(prog_i.wdata);
                        end
                        CMD_ERASE_ALL:
                        begin
                            d.perr = !p_ok;
                            d.fl.erase = 1'b1;
                        end
                        CMD_SET_PROT:
                        begin
                            // an erased row reads open, so a row is set to a level other than open once per erase
                            d.perr = !p_ok || row_lvl != LVL_OPEN;
                            if (!d.perr)
                                d.prot[prog_i.addr[15:8]] = prog_i.lvl;
                            d.st = ST_PDONE;
                        end
                        default:
                            d.perr = 1'b1;
                    endcase
                    if (d.perr)
                        d.st = ST_PDONE;
                end
                else if (fetch_req_i)
                begin
                    d.ferr = 1'b0;
                    d.faddr = fetch_addr_i[15:0];
                    if (fetch_addr_i[16])
                    begin
                        d.ferr = 1'b1;
                        d.st = ST_RESP;
                    end
                    else if (q.cache_en && hit)
                    begin
                        d.fdata = hit_word[{fetch_addr_i[2:0], 3'h0} +: 8];
                        d.st = ST_RESP;
                    end
                    else
                    begin
                        d.byp = !q.cache_en;
                        d.lbad = 1'b0;
                        d.cnt = q.cache_en ? 3'h0 : fetch_addr_i[5:3];
                        d.fl = '{aux: 1'b0, grp: {fetch_addr_i[15:6], d.cnt}, wr: 1'b0,
                                 erase: 1'b0, wdata: 64'h0, wchk: ERASED_CHK};
                        d.st = ST_FILL;
                    end
                end
            end
            ST_FILL:
            begin
                if (flash_ack_i)
                begin
                    if (q.ecc_en && (dec.sbe || dec.dbe))
                    begin
                        // a set beats a clear written in the same cycle
                        d.sbe = d.sbe | dec.sbe;
                        d.dbe = d.dbe | dec.dbe;
                        d.eaddr = q.fl.grp;
                    end
                    if (q.ecc_en && dec.dbe)
                    begin
                        d.lbad = 1'b1;
                        if (q.cnt == q.faddr[5:3])
                            d.ferr = 1'b1;
                    end
                    mem_we = !q.byp;
                    if (q.cnt == q.faddr[5:3])
                        d.fdata = fill_word[{q.faddr[2:0], 3'h0} +: 8];
                    if (q.byp || q.cnt == 3'h7)
                    begin
                        d.st = ST_RESP;
                        if (!q.byp)
                        begin
                            d.tag[q.rr] = q.faddr[15:6];
                            // a line holding an uncorrectable word is not kept
                            d.vld[q.rr] = !(q.lbad || (q.ecc_en && dec.dbe)) && d.cache_en;
                            d.rr = q.rr + 3'h1;
                        end
                    end
                    else
                    begin
                        d.cnt = q.cnt + 3'h1;
                        d.fl.grp = {q.faddr[15:6], d.cnt};
                    end
                end
            end
            ST_RESP:
                d.st = ST_IDLE;
            ST_PROG:
            begin
                if (flash_ack_i)
                begin
                    if (q.pc.cmd == CMD_READ)
                        d.prdata = (q.ecc_en && !q.pc.addr[16]) ? dec.data : flash_data_i;
                    else
                        d.vld = '0;
                    if (q.pc.cmd == CMD_ERASE_ALL)
                        d.prot = '0;
                    d.st = ST_PDONE;
                end
            end
            ST_PDONE:
                d.st = ST_IDLE;
            default:
                d.st = ST_IDLE;
        endcase
        d.irq = d.irq_en && (d.sbe || d.dbe);
        d.pwr = (d.st == ST_FILL) || (d.st == ST_PROG);
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{st: ST_IDLE, cache_en: RST_CACHE_EN, ecc_en: RST_ECC_EN,
                   irq_en: RST_IRQ_EN, default: '0};
        else
            q <= d;
    end

    always_ff @(posedge mclk_i)
    begin
        if (mem_we)
            line_mem[mem_wi] <= mem_wd;
    end

    assign reg_rdata_o   = q.rdata;
    assign fetch_rdy_o   = q.st == ST_RESP;
    assign fetch_data_o  = q.fdata;
    assign fetch_err_o   = q.ferr;
    assign prog_done_o   = q.st == ST_PDONE;
    assign prog_err_o    = q.perr;
    assign prog_rdata_o  = q.prdata;
    assign flash_o       = q.fl;
    assign flash_req_o   = (q.st == ST_FILL) || (q.st == ST_PROG);
    assign flash_pwr_o   = q.pwr;
    assign ecc_irq_o     = q.irq;
    assign dbg_port_en_o = !q.secure;

    a_hit_serves: assert property (q.st == ST_IDLE && fetch_req_i && !prog_req_i
        && q.cache_en && hit && !fetch_addr_i[16] |=> fetch_rdy_o && !flash_req_o)
        else $error("cache hit not answered next cycle");
    a_aux_fetch: assert property (q.st == ST_IDLE && fetch_req_i && !prog_req_i
        && fetch_addr_i[16] |=> fetch_rdy_o && fetch_err_o)
        else $error("fetch from auxiliary region not faulted");
    a_fill_line: assert property (q.st == ST_FILL && !q.byp && flash_ack_i
        && q.cnt == 3'h7 |=> fetch_rdy_o ##1 !fetch_rdy_o)
        else $error("line fill did not end in one answer");
    a_fill_count: assert property (q.st == ST_IDLE && fetch_req_i && !prog_req_i
        && q.cache_en && !hit && !fetch_addr_i[16] |=> flash_req_o && flash_o.grp[2:0] == 3'h0)
        else $error("line fill not started at first group");
    a_prog_first: assert property (q.st == ST_IDLE && prog_req_i && fetch_req_i
        |=> !fetch_rdy_o [*2])
        else $error("fetch answered while programming");
    a_full_nowr: assert property (q.st == ST_IDLE && prog_req_i
        && prog_i.cmd == CMD_PROGRAM && row_lvl == LVL_FULL |=> prog_done_o && prog_err_o)
        else $error("write to fully protected row accepted");
    a_fact_noext: assert property (q.st == ST_IDLE && prog_req_i && p_ext
        && prog_i.cmd == CMD_READ && row_lvl == LVL_FACTORY |=> prog_done_o && prog_err_o)
        else $error("external read of factory row accepted");
    a_field_nowr: assert property (q.st == ST_IDLE && prog_req_i && p_ext
        && prog_i.cmd == CMD_PROGRAM && row_lvl == LVL_FIELD |=> prog_err_o)
        else $error("external write of field row accepted");
    a_open_read: assert property (q.st == ST_IDLE && prog_req_i && p_ok
        && prog_i.cmd == CMD_READ && row_lvl == LVL_OPEN |=> !prog_err_o && flash_req_o)
        else $error("read of open row refused");
    a_prot_lock: assert property (q.st == ST_IDLE && prog_req_i
        && prog_i.cmd == CMD_SET_PROT && row_lvl != LVL_OPEN |=> prog_err_o && $stable(q.prot))
        else $error("level of a set row changed without erase");
    a_secure_ext: assert property (q.secure && q.st == ST_IDLE && prog_req_i
        && prog_i.src != SRC_INT |=> prog_done_o && prog_err_o && !dbg_port_en_o)
        else $error("external request accepted after security");
    a_dbe_flag: assert property (q.st == ST_FILL && q.ecc_en && flash_ack_i
        && dec.dbe |=> q.dbe ##1 q.dbe)
        else $error("double error not recorded");
    a_irq_mask: assert property (!q.irq_en && !reg_wr_i |=> !ecc_irq_o)
        else $error("error interrupt without enable");
    a_aux_nowr: assert property (q.st == ST_IDLE && prog_req_i && q.ecc_en
        && prog_i.cmd == CMD_PROGRAM && prog_i.addr[16] |=> prog_done_o && prog_err_o)
        else $error("auxiliary write accepted with correction on");
    a_pwr_idle: assert property (q.st == ST_IDLE && !prog_req_i && !fetch_req_i
        |=> !flash_pwr_o && !flash_req_o)
        else $error("flash powered while idle");
endmodule

// [test/fcep_flash_model.sv]
// flash array model: group reads, group writes, whole erase
module fcep_flash_model
    import fcep_pkg::*;
(
    input  wire logic        clk_i,          // clock
    input  wire logic        req_i,          // access request
    input  wire fcep_flash_t fl_i,           // access command
    input  wire logic        slow_i,         // answer late
    input  wire logic [1:0]  flip_i,         // data bits to corrupt
    output logic             ack_o = 1'b0,   // access done
    output logic      [63:0] data_o = 64'h0, // read group
    output logic      [7:0]  chk_o = 8'h0,   // its check byte
    output logic      [7:0]  wchk_o = 8'h0   // last written check byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] mem [int];
    logic [7:0]  cm  [int];
    int          wt = 0;
    int          k;
    always @(posedge clk_i)
    begin
        k = {fl_i.aux, fl_i.grp};
        ack_o <= 1'b0;
        // released lines toggle so a stale group never looks valid
        data_o <= ~data_o;
        chk_o <= ~chk_o;
        if (!req_i || ack_o)
            wt <= slow_i ? 3 : 0;
        else if (wt > 0)
            wt <= wt - 1;
        else
        begin
            ack_o <= 1'b1;
            wt <= slow_i ? 3 : 0;
            if (fl_i.erase)
            begin
                mem.delete();
                cm.delete();
            end
            else if (fl_i.wr)
            begin
                mem[k] = fl_i.wdata;
                cm[k] = fl_i.wchk;
                wchk_o <= fl_i.wchk;
            end
            data_o <= (mem.exists(k) ? mem[k] : '1) ^ {62'h0, flip_i[1], |flip_i};
            chk_o <= cm.exists(k) ? cm[k] : 8'hFF;
        end
    end
endmodule

// [test/testbench.sv]
// self-checking bench of the flash cache, correction and protection block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench
    import fcep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 0, nrst_i = 0, rwr = 0, rrd = 0, freq = 0, preq = 0, slow = 0;
    logic [3:0] radr = 4'h0, alw [4] = '{4'hF, 4'hB, 4'h3, 4'h1};
    logic [31:0] rwd = 32'h0, rdat, rv, seed = 32'h4B701356;
    logic [16:0] fadr = 17'h0, ra;
    logic [1:0] flip = 2'h0;
    fcep_prog_t pr = '0;
    fcep_flash_t fl;
    logic frdy, ferr, pdone, perr, freqo, fack, irq, dbg, p_err, f_err, fpwr;
    logic [7:0] fdat, chk, wchk, f_dat;
    logic [63:0] prd, fdata, p_rd, wd;
    logic [63:0] exp_mem [int];
    int err_count = 0, checks_done = 0, acks = 0, n, i, j2;
    int ln [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 8, 0};
    time p_t, f_t;
    fcep_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(radr), .reg_wdata_i(rwd),
        .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat), .fetch_req_i(freq),
        .fetch_addr_i(fadr), .fetch_rdy_o(frdy), .fetch_data_o(fdat), .fetch_err_o(ferr),
        .prog_req_i(preq), .prog_i(pr), .prog_done_o(pdone), .prog_err_o(perr),
        .prog_rdata_o(prd), .flash_o(fl), .flash_req_o(freqo), .flash_pwr_o(fpwr),
        .flash_ack_i(fack), .flash_data_i(fdata), .flash_chk_i(chk), .ecc_irq_o(irq),
        .dbg_port_en_o(dbg));
    fcep_flash_model fm (.clk_i(mclk_i), .req_i(freqo), .fl_i(fl), .slow_i(slow),
        .flip_i(flip), .ack_o(fack), .data_o(fdata), .chk_o(chk), .wchk_o(wchk));
    initial
        forever #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
        if (fack === 1'b1)
        begin
            acks++;
            `CHK(fpwr, 1'b1)
        end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim;
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for an answer pulse; f picks programming or fetch
    task automatic await(input bit f);
        int k;
        for (k = 0; k < 300; k++)
        begin
            @(posedge mclk_i);
            if ((f ? pdone : frdy) === 1'b1)
                break;
        end
        err_count += (k == 300);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        radr <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge mclk_i);
        rwr <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        radr <= a;
        rrd <= 1'b1;
        @(posedge mclk_i);
        rrd <= 1'b0;
        @(negedge mclk_i) rv = rdat;
        @(posedge mclk_i);
    endtask
    task automatic fetch(input logic [16:0] a);
        n = acks;
        fadr <= a;
        freq <= 1'b1;
        slow <= seed[0];
        await(0);
        freq <= 1'b0;
        fadr <= ~fadr;
        f_dat = fdat;
        f_err = ferr;
        f_t = $time;
        @(posedge mclk_i);
    endtask
    task automatic prog(input fcep_cmd_t c, input fcep_src_t s, input logic [16:0] a,
                        input fcep_lvl_t l);
        seed = lfsr(seed);
        wd = {seed, lfsr(seed)};
        pr <= {c, s, a, wd, l};
        preq <= 1'b1;
        await(1);
        preq <= 1'b0;
        pr <= ~pr;
        p_err = perr;
        p_rd = prd;
        p_t = $time;
        if (c == CMD_PROGRAM && perr === 1'b0)
            exp_mem[a[16:3]] = wd;
        @(posedge mclk_i);
    endtask
    initial
    begin
        #500000;
        err_count++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        `CHK(dbg, 1'b1)
        rd(OFF_CTRL);
        `CHK(rv, 32'h3)
        rd(4'hC);
        `CHK(rv, 32'h0)
        for (i = 0; i < 72; i++)
        begin
            prog(CMD_PROGRAM, SRC_INT, 17'(i * 8), LVL_OPEN);
            `CHK(p_err, 1'b0)
        end
        // eight distinct lines fill the cache, the ninth evicts the oldest
        foreach (ln[i])
        begin
            seed = lfsr(seed);
            fetch(17'(ln[i] * 64 + seed[5:0]));
            `CHK(f_dat, 8'(exp_mem[ln[i] * 8 + seed[5:3]] >> (8 * seed[2:0])))
            `CHK(acks - n, (i == 8) ? 0 : 8)
        end
        `CHK(fpwr, 1'b0)
        fetch(17'h10000);
        `CHK(f_err, 1'b1)
        `CHK(acks - n, 0)
        wr(OFF_CTRL, 32'h6);
        fetch(17'h2D);
        `CHK(acks - n, 1)
        flip <= 2'h1;
        fetch(17'h2D);
        `CHK(f_dat, exp_mem[5][47:40])
        `CHK(f_err, 1'b0)
        rd(OFF_STAT);
        `CHK(rv[1:0], 2'h1)
        `CHK(irq, 1'b1)
        rd(OFF_EADR);
        `CHK(rv, 32'h5)
        wr(OFF_STAT, 32'h3);
        flip <= 2'h2;
        fetch(17'h2D);
        `CHK(f_err, 1'b1)
        rd(OFF_STAT);
        `CHK(rv[1:0], 2'h2)
        wr(OFF_CTRL, 32'h2);
        rd(OFF_STAT);
        `CHK(irq, 1'b0)
        wr(OFF_STAT, 32'h3);
        flip <= 2'h0;
        wr(OFF_CTRL, 32'h1);
        prog(CMD_PROGRAM, SRC_INT, 17'h10008, LVL_OPEN);
        `CHK(p_err, 1'b0)
        `CHK(wchk, 8'hFF)
        prog(CMD_READ, SRC_INT, 17'h10008, LVL_OPEN);
        `CHK(p_rd, exp_mem[32'h2001])
        wr(OFF_CTRL, 32'h3);
        prog(CMD_PROGRAM, SRC_INT, 17'h10010, LVL_OPEN);
        `CHK(p_err, 1'b1)
        fork
            fetch(17'h0);
            prog(CMD_READ, SRC_INT, 17'h0, LVL_OPEN);
        join
        `CHK(p_t < f_t, 1'b1)
        `CHK(p_rd, exp_mem[0])
        for (i = 0; i < 4; i++)
        begin
            ra = 17'(i * 256 + 1024);
            prog(CMD_PROGRAM, SRC_INT, ra, LVL_OPEN);
            prog(CMD_SET_PROT, SRC_INT, ra, fcep_lvl_t'(i));
            `CHK(p_err, 1'b0)
            prog(CMD_SET_PROT, SRC_INT, ra, fcep_lvl_t'(i));
            `CHK(p_err, i != 0)
            for (j2 = 0; j2 < 4; j2++)
            begin
                prog(j2[0] ? CMD_PROGRAM : CMD_READ,
                     j2 == 3 ? SRC_JTAG : j2 == 2 ? SRC_SWD : SRC_INT, ra, LVL_OPEN);
                `CHK(p_err, !alw[i][j2])
                if (!j2[0] && alw[i][j2])
                    `CHK(p_rd, exp_mem[ra[16:3]])
            end
        end
        prog(CMD_ERASE_ALL, SRC_INT, 17'h0, LVL_OPEN);
        `CHK(p_err, 1'b0)
        prog(CMD_PROGRAM, SRC_JTAG, 17'h700, LVL_OPEN);
        `CHK(p_err, 1'b0)
        prog(CMD_READ, SRC_RSVD, 17'h0, LVL_OPEN);
        `CHK(p_err, 1'b1)
        wr(OFF_CTRL, 32'hB);
        wr(OFF_CTRL, 32'h3);
        rd(OFF_STAT);
        `CHK(rv[3], 1'b1)
        `CHK(dbg, 1'b0)
        prog(CMD_READ, SRC_SWD, 17'h700, LVL_OPEN);
        `CHK(p_err, 1'b1)
        prog(CMD_READ, SRC_INT, 17'h700, LVL_OPEN);
        `CHK(p_rd, exp_mem[224])
        end_sim;
    end
endmodule
